// file: shared/sfs_regs.vh
// register map, field positions, reset values and timing counts of the servo status block
`ifndef SFS_REGS_VH
`define SFS_REGS_VH

// register byte offsets
`define SFS_OFS_CTRL        8'h00
`define SFS_OFS_WRAP_LIMIT  8'h04
`define SFS_OFS_MOTION_LVL  8'h08
`define SFS_OFS_STATE       8'h0C
`define SFS_OFS_ENC_LIMIT   8'h10
`define SFS_OFS_INT_STATUS  8'h14
`define SFS_OFS_INT_MASK    8'h18

// control register fields
`define SFS_CTRL_CODE_SEL   0
`define SFS_CTRL_CAUT_PIN   1
`define SFS_CTRL_MOTN_PIN   2

// interrupt status / mask fields
`define SFS_INT_FAULT_SET   0
`define SFS_INT_FAULT_CLR   1
`define SFS_INT_ENC_DONE    2
`define SFS_INT_CAUTION     3
`define SFS_INT_W           4

// reset values and motion level limits
`define SFS_RST_CTRL        3'h0
`define SFS_RST_WRAP_LIMIT  16'hFFFF
`define SFS_RST_MOTION_LVL  14'h0014
`define SFS_MOTION_LVL_MIN  14'h0001
`define SFS_MOTION_LVL_MAX  14'h2710

// fault code pin levels {line3, line2, line1}; 1 = off (high), 0 = on (low)
`define SFS_CODE_IDLE       3'h7
`define SFS_CODE_MISMATCH   3'h2

// utility function number of the encoder limit write
`define SFS_FN_ENC_WRITE    8'h13

// operator panel states
`define SFS_OP_IDLE         2'h0
`define SFS_OP_UTIL         2'h1
`define SFS_OP_PROMPT       2'h2
`define SFS_OP_DONE         2'h3

// timing: clock period and one-second key hold / done flash
`define SFS_CLK_NS          4
`define SFS_HOLD_NS         1000000000
`define SFS_HOLD_CYC        (`SFS_HOLD_NS / `SFS_CLK_NS)

`endif

// file: logic/sfs_top.v
// servo fault, caution and motion status outputs with operator limit write
// How it works
// - limit param differing from encoder raises mismatch fault
// - mismatch code: line1 low, line2 high, line3 low
// - mode, up/down select; shift held one second
// - mode at prompt writes encoder, flashes done
// - written encoder limit effective after power cycle
// - fault flag closed normal, open on error
// - fault type shown on three code lines
// - clear input clears faults, not encoder ones
// - up and down together clear fault
// - external operator reset key clears fault
// - caution output on in caution, if assigned and no fault latched
// - code select: caution codes too, after restart
// - motion output on when speed reaches level
// - motion level 1..10000, default 20, immediate
//
// Design decisions made here: strobed register access and the register offsets.
`include "sfs_regs.vh"

module sfs_top #(
	parameter HOLD_CYC = `SFS_HOLD_CYC
) (
	input  wire        MCLK,
	input  wire        RSTN,
	input  wire [7:0]  REG_ADDR,
	input  wire [31:0] REG_WDATA,
	input  wire        REG_WR,
	input  wire        REG_RD,
	output reg  [31:0] REG_RDATA,
	output wire        IRQ,
	input  wire        KEY_MODE,
	input  wire        KEY_UP,
	input  wire        KEY_DOWN,
	input  wire        KEY_SHIFT,
	input  wire        EXT_FAULT_RESET_KEY,
	input  wire        FAULT_CLEAR_INPUT,
	input  wire        FAULT_REQ,
	input  wire [2:0]  FAULT_REQ_CODE,
	input  wire        FAULT_REQ_ENC,
	input  wire        CAUTION_ACTIVE,
	input  wire [2:0]  CAUTION_CODE,
	input  wire [15:0] ENC_LIMIT_STORED,
	output reg         ENC_WRITE,
	output reg  [15:0] ENC_WRITE_DATA,
	input  wire [15:0] MOTOR_SPEED,
	output reg         FAULT_FLAG_OUTPUT,
	output reg         FAULT_CODE_LINE_1,
	output reg         FAULT_CODE_LINE_2,
	output reg         FAULT_CODE_LINE_3,
	output reg         CAUTION_OUTPUT,
	output reg         MOTION_DETECT_OUTPUT,
	output wire [1:0]  PANEL_STATE
);

	reg  [2:0]  ctrl_ff;            // code select, caution pin, motion pin
	reg  [15:0] turn_wrap_limit_ff; // drive side turn-wrap limit
	reg  [13:0] motion_level_ff;    // motion detect level in 1 min^-1
	reg  [3:0]  int_status_ff;      // sticky events
	reg  [3:0]  int_mask_ff;        // interrupt enables
	reg         boot_ff;            // low only in the first cycle after reset
	reg  [15:0] enc_limit_live_ff;  // encoder limit caught at power-up
	reg         code_sel_live_ff;   // code select caught at power-up
	reg         fault_ff;           // a fault is latched
	reg         fault_enc_ff;       // latched fault needs a power cycle
	reg  [2:0]  fault_code_ff;      // latched code, pin levels
	reg  [1:0]  op_state_ff;        // operator panel state
	reg  [7:0]  fn_sel_ff;          // selected utility function number
	reg  [27:0] hold_cnt_ff;        // shift hold and done flash timer
	reg         hold_seen_ff;       // shift hold already acted on
	reg         mode_d_ff;          // previous key levels for edges
	reg         up_d_ff;
	reg         down_d_ff;
	reg         both_d_ff;
	reg         ext_d_ff;
	reg         clr_d_ff;
	reg         caut_d_ff;

	wire        mode_edge = KEY_MODE & ~mode_d_ff;
	wire        both_keys = KEY_UP & KEY_DOWN;
	wire        up_edge   = KEY_UP & ~up_d_ff & ~KEY_DOWN;
	wire        down_edge = KEY_DOWN & ~down_d_ff & ~KEY_UP;
	wire        hold_hit  = KEY_SHIFT & ~hold_seen_ff
	                        & (hold_cnt_ff == HOLD_CYC[27:0] - 28'h0000001);

	wire        mismatch  = boot_ff & (turn_wrap_limit_ff != enc_limit_live_ff);

	// fault sources; the built-in mismatch beats an external request
	wire        new_fault = mismatch | FAULT_REQ;
	wire [2:0]  new_code  = mismatch ? `SFS_CODE_MISMATCH : FAULT_REQ_CODE;
	// mismatch lives in the encoder, so it is encoder related
	wire        new_enc   = mismatch | FAULT_REQ_ENC;

	wire        clr_pin   = FAULT_CLEAR_INPUT & ~clr_d_ff;
	wire        clr_panel = both_keys & ~both_d_ff;
	wire        clr_ext   = EXT_FAULT_RESET_KEY & ~ext_d_ff;
	// encoder-related faults ignore every clear; only reset removes them
	wire        clr_ok    = fault_ff & ~fault_enc_ff & (clr_pin | clr_panel | clr_ext);
	wire        fault_set = new_fault & ~fault_ff;

	wire        wr_ctrl   = REG_WR & (REG_ADDR == `SFS_OFS_CTRL);
	wire        wr_limit  = REG_WR & (REG_ADDR == `SFS_OFS_WRAP_LIMIT);
	wire        wr_level  = REG_WR & (REG_ADDR == `SFS_OFS_MOTION_LVL);
	wire        wr_stat   = REG_WR & (REG_ADDR == `SFS_OFS_INT_STATUS);
	wire        wr_mask   = REG_WR & (REG_ADDR == `SFS_OFS_INT_MASK);
	wire        enc_wr    = (op_state_ff == `SFS_OP_PROMPT) & mode_edge;

	reg  [13:0] nxt_level;          // clamped motion level
	reg  [3:0]  nxt_int_status;
	reg  [2:0]  nxt_code;
	reg  [31:0] nxt_rdata;

	assign IRQ         = |(int_status_ff & int_mask_ff);
	assign PANEL_STATE = op_state_ff;

	always @* begin
		if (REG_WDATA[31:0] < {18'h00000, `SFS_MOTION_LVL_MIN})
			nxt_level = `SFS_MOTION_LVL_MIN;
		else if (REG_WDATA[31:0] > {18'h00000, `SFS_MOTION_LVL_MAX})
			nxt_level = `SFS_MOTION_LVL_MAX;
		else
			nxt_level = REG_WDATA[13:0];
	end

	// software registers; level change acts at once
	always @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			ctrl_ff            <= `SFS_RST_CTRL;
			turn_wrap_limit_ff <= `SFS_RST_WRAP_LIMIT;
			motion_level_ff    <= `SFS_RST_MOTION_LVL;
			int_mask_ff        <= 4'h0;
		end else begin
			if (wr_ctrl)
				ctrl_ff <= REG_WDATA[2:0];
			if (wr_limit)
				turn_wrap_limit_ff <= REG_WDATA[15:0];
			if (wr_level)
				motion_level_ff <= nxt_level;
			if (wr_mask)
				int_mask_ff <= REG_WDATA[3:0];
		end
	end

	// sticky events: a new event outranks a write-one clear
	always @* begin
		nxt_int_status = int_status_ff;
		if (wr_stat)
			nxt_int_status = int_status_ff & ~REG_WDATA[3:0];
		nxt_int_status[`SFS_INT_FAULT_SET] = nxt_int_status[`SFS_INT_FAULT_SET] | fault_set;
		nxt_int_status[`SFS_INT_FAULT_CLR] = nxt_int_status[`SFS_INT_FAULT_CLR] | clr_ok;
		nxt_int_status[`SFS_INT_ENC_DONE]  = nxt_int_status[`SFS_INT_ENC_DONE] | enc_wr;
		nxt_int_status[`SFS_INT_CAUTION]   = nxt_int_status[`SFS_INT_CAUTION]
		                                     | (CAUTION_ACTIVE & ~caut_d_ff);
	end

	// power-up capture; the reset takes constants, ports are caught after it
	always @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			boot_ff           <= 1'b0;
			enc_limit_live_ff <= 16'h0000;
			code_sel_live_ff  <= 1'b0;
		end else begin
			boot_ff <= 1'b1;
			if (!boot_ff) begin
				enc_limit_live_ff <= ENC_LIMIT_STORED;
				// select applies after restart; a write in the boot edge counts
				// since the reset has just cleared the control register
				code_sel_live_ff  <= wr_ctrl ? REG_WDATA[`SFS_CTRL_CODE_SEL]
				                             : ctrl_ff[`SFS_CTRL_CODE_SEL];
			end
		end
	end

	// fault latch and edge history
	always @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			fault_ff      <= 1'b0;
			fault_enc_ff  <= 1'b0;
			fault_code_ff <= `SFS_CODE_IDLE;
			int_status_ff <= 4'h0;
			mode_d_ff     <= 1'b0;
			up_d_ff       <= 1'b0;
			down_d_ff     <= 1'b0;
			both_d_ff     <= 1'b0;
			ext_d_ff      <= 1'b0;
			clr_d_ff      <= 1'b0;
			caut_d_ff     <= 1'b0;
		end else begin
			int_status_ff <= nxt_int_status;
			mode_d_ff     <= KEY_MODE;
			up_d_ff       <= KEY_UP;
			down_d_ff     <= KEY_DOWN;
			both_d_ff     <= both_keys;
			ext_d_ff      <= EXT_FAULT_RESET_KEY;
			clr_d_ff      <= FAULT_CLEAR_INPUT;
			caut_d_ff     <= CAUTION_ACTIVE;
			if (fault_set) begin
				fault_ff      <= 1'b1;
				fault_enc_ff  <= new_enc;
				fault_code_ff <= new_code;
			end else if (clr_ok) begin
				// a fault still present re-latches in the next cycle
				fault_ff      <= 1'b0;
				fault_enc_ff  <= 1'b0;
				fault_code_ff <= `SFS_CODE_IDLE;
			end
		end
	end

	// operator panel sequence with one-second shift hold
	always @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			op_state_ff    <= `SFS_OP_IDLE;
			fn_sel_ff      <= 8'h00;
			hold_cnt_ff    <= 28'h0000000;
			hold_seen_ff   <= 1'b0;
			ENC_WRITE      <= 1'b0;
			ENC_WRITE_DATA <= 16'h0000;
		end else begin
			ENC_WRITE <= enc_wr;
			// shift hold timer; the done flash reuses it without the key
			if (op_state_ff == `SFS_OP_DONE)
				hold_cnt_ff <= hold_cnt_ff + 28'h0000001;
			else if (KEY_SHIFT & ~hold_seen_ff & ~hold_hit)
				hold_cnt_ff <= hold_cnt_ff + 28'h0000001;
			else
				hold_cnt_ff <= 28'h0000000;
			if (hold_hit)
				hold_seen_ff <= 1'b1;
			else if (!KEY_SHIFT)
				hold_seen_ff <= 1'b0;
			case (op_state_ff)
				`SFS_OP_IDLE: begin
					if (mode_edge) begin
						op_state_ff <= `SFS_OP_UTIL;
						fn_sel_ff   <= 8'h00;
					end
				end
				`SFS_OP_UTIL: begin
					if (mode_edge)
						op_state_ff <= `SFS_OP_IDLE;
					else if (up_edge)
						fn_sel_ff <= fn_sel_ff + 8'h01;
					else if (down_edge)
						fn_sel_ff <= fn_sel_ff - 8'h01;
					else if (hold_hit && fn_sel_ff == `SFS_FN_ENC_WRITE)
						op_state_ff <= `SFS_OP_PROMPT;
				end
				`SFS_OP_PROMPT: begin
					if (enc_wr) begin
						op_state_ff    <= `SFS_OP_DONE;
						ENC_WRITE_DATA <= turn_wrap_limit_ff;
					end else if (hold_hit)
						op_state_ff <= `SFS_OP_UTIL;
				end
				`SFS_OP_DONE: begin
					// one second flash, back to prompt
					if (hold_cnt_ff == HOLD_CYC[27:0] - 28'h0000001)
						op_state_ff <= `SFS_OP_PROMPT;
				end
				default: op_state_ff <= `SFS_OP_IDLE;
			endcase
		end
	end

	// code lines: fault first, caution codes when selected
	always @* begin
		if (fault_ff)
			nxt_code = fault_code_ff;
		else if (code_sel_live_ff && CAUTION_ACTIVE)
			nxt_code = CAUTION_CODE;
		else
			nxt_code = `SFS_CODE_IDLE;
	end

	// pin outputs from flip-flops
	always @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) begin
			FAULT_FLAG_OUTPUT    <= 1'b1;
			FAULT_CODE_LINE_1    <= 1'b1;
			FAULT_CODE_LINE_2    <= 1'b1;
			FAULT_CODE_LINE_3    <= 1'b1;
			CAUTION_OUTPUT       <= 1'b0;
			MOTION_DETECT_OUTPUT <= 1'b0;
		end else begin
			// flag open while a fault is latched
			FAULT_FLAG_OUTPUT    <= ~fault_ff;
			FAULT_CODE_LINE_1    <= nxt_code[0];
			FAULT_CODE_LINE_2    <= nxt_code[1];
			FAULT_CODE_LINE_3    <= nxt_code[2];
			// caution only on an assigned pin
			CAUTION_OUTPUT       <= ctrl_ff[`SFS_CTRL_CAUT_PIN] & CAUTION_ACTIVE & ~fault_ff;
			MOTION_DETECT_OUTPUT <= ctrl_ff[`SFS_CTRL_MOTN_PIN]
			                        & (MOTOR_SPEED >= {2'h0, motion_level_ff});
		end
	end

	// read mux; unmapped offsets read zero
	always @* begin
		case (REG_ADDR)
			`SFS_OFS_CTRL:       nxt_rdata = {29'h00000000, ctrl_ff};
			`SFS_OFS_WRAP_LIMIT: nxt_rdata = {16'h0000, turn_wrap_limit_ff};
			`SFS_OFS_MOTION_LVL: nxt_rdata = {18'h00000, motion_level_ff};
			`SFS_OFS_STATE:      nxt_rdata = {22'h000000, (fn_sel_ff[3:0] == 4'h0),
			                                  code_sel_live_ff, op_state_ff, mismatch,
			                                  fault_code_ff, fault_enc_ff, fault_ff};
			`SFS_OFS_ENC_LIMIT:  nxt_rdata = {16'h0000, enc_limit_live_ff};
			`SFS_OFS_INT_STATUS: nxt_rdata = {28'h0000000, int_status_ff};
			`SFS_OFS_INT_MASK:   nxt_rdata = {28'h0000000, int_mask_ff};
			default:             nxt_rdata = 32'h00000000;
		endcase
	end

	// read data stands for one cycle only
	always @(posedge MCLK or negedge RSTN) begin
		if (!RSTN)
			REG_RDATA <= 32'h00000000;
		else if (REG_RD)
			REG_RDATA <= nxt_rdata;
		else
			REG_RDATA <= 32'h00000000;
	end

endmodule // sfs_top

// file: testbench/sfs_top_monitor.sv
// port checker for the servo status block
`include "sfs_regs.vh"
module sfs_top_monitor #(
	parameter HOLD_CYC = 16
) (
	input wire        MCLK,
	input wire        RSTN,
	input wire        REG_RD,
	input wire [31:0] REG_RDATA,
	input wire        FAULT_REQ,
	input wire        CAUTION_ACTIVE,
	input wire        ENC_WRITE,
	input wire [15:0] MOTOR_SPEED,
	input wire        FAULT_FLAG_OUTPUT,
	input wire        FAULT_CODE_LINE_1,
	input wire        FAULT_CODE_LINE_2,
	input wire        FAULT_CODE_LINE_3,
	input wire        CAUTION_OUTPUT,
	input wire        MOTION_DETECT_OUTPUT,
	input wire [1:0]  PANEL_STATE
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (!RSTN);
	wire [2:0]   code = {FAULT_CODE_LINE_3, FAULT_CODE_LINE_2, FAULT_CODE_LINE_1}; // pin levels
	logic [31:0] done_cnt_ff; // edges spent in the done flash
	// count the flash so its exit is checked to the exact cycle
	always_ff @(posedge MCLK or negedge RSTN) begin
		if (!RSTN) done_cnt_ff <= 32'h0;
		else if (PANEL_STATE == `SFS_OP_DONE) done_cnt_ff <= done_cnt_ff + 32'h1;
		else done_cnt_ff <= 32'h0;
	end
	a_flag_opens: assert property (FAULT_REQ && FAULT_FLAG_OUTPUT |-> ##[1:3] !FAULT_FLAG_OUTPUT)
		else $error("fault flag stayed closed");
	a_code_held: assert property (!FAULT_FLAG_OUTPUT && !$past(FAULT_FLAG_OUTPUT) |-> $stable(code))
		else $error("fault code moved");
	a_code_idle: assert property ($rose(FAULT_FLAG_OUTPUT) && !$past(CAUTION_ACTIVE)
		|-> code == `SFS_CODE_IDLE)
		else $error("code not idle after clear");
	a_caution_cause: assert property (CAUTION_OUTPUT |-> $past(CAUTION_ACTIVE) && FAULT_FLAG_OUTPUT)
		else $error("caution without cause");
	a_motion_zero: assert property (MOTOR_SPEED == 16'h0000 |=> !MOTION_DETECT_OUTPUT)
		else $error("motion at zero speed");
	a_write_pulse: assert property (ENC_WRITE |-> PANEL_STATE == `SFS_OP_DONE ##1 !ENC_WRITE)
		else $error("encoder write pulse wrong");
	a_done_length: assert property ($past(PANEL_STATE) == `SFS_OP_DONE && PANEL_STATE != `SFS_OP_DONE
		|-> PANEL_STATE == `SFS_OP_PROMPT && done_cnt_ff == HOLD_CYC)
		else $error("done flash length wrong");
	a_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
		else $error("read data outside its cycle");
	c_fault: cover property ($fell(FAULT_FLAG_OUTPUT));
	c_write: cover property (ENC_WRITE);
	c_motion: cover property ($rose(MOTION_DETECT_OUTPUT));
endmodule // sfs_top_monitor

bind sfs_top sfs_top_monitor #(.HOLD_CYC(HOLD_CYC)) i_sfs_top_monitor (
	.MCLK(MCLK), .RSTN(RSTN), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .FAULT_REQ(FAULT_REQ),
	.CAUTION_ACTIVE(CAUTION_ACTIVE), .ENC_WRITE(ENC_WRITE), .MOTOR_SPEED(MOTOR_SPEED),
	.FAULT_FLAG_OUTPUT(FAULT_FLAG_OUTPUT), .FAULT_CODE_LINE_1(FAULT_CODE_LINE_1),
	.FAULT_CODE_LINE_2(FAULT_CODE_LINE_2), .FAULT_CODE_LINE_3(FAULT_CODE_LINE_3),
	.CAUTION_OUTPUT(CAUTION_OUTPUT), .MOTION_DETECT_OUTPUT(MOTION_DETECT_OUTPUT),
	.PANEL_STATE(PANEL_STATE)
);

// file: testbench/sfs_host_model.sv
// host controller, power cut-off and encoder memory around the status block
module sfs_host_model (
	input wire          mclk,
	input wire          clr_req,
	input wire          flag,
	input wire          enc_wr,
	input wire   [15:0] enc_wr_data,
	output logic [15:0] enc_limit_ff,
	output logic        clear_out,
	output logic        main_power
);
	initial enc_limit_ff = 16'hFFFF; // encoder keeps its limit across drive resets
	assign main_power = flag;
	assign clear_out = clr_req; // host drives the clear line level
	// encoder memory takes the written limit
	always @(posedge mclk) begin
		if (enc_wr) enc_limit_ff <= enc_wr_data;
	end
endmodule // sfs_host_model

// file: testbench/tb.sv
// self-checking bench for the servo status block
`include "sfs_regs.vh"
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int HOLD = 16; // shortened one-second hold
	logic        mclk = 0, rstn = 0, wr = 0, rd = 0, ext_key = 0, clr_req = 0, freq = 0, caut = 0;
	logic        fenc = 0; // marks the requested fault as encoder related
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, d;
	logic [3:0]  keys = 4'h0; // mode, up, down, shift
	logic [2:0]  freq_code = 3'h0, caut_code = 3'h0, code;
	logic [15:0] enc_lim, enc_wdata, speed = 16'h0;
	logic        irq, clr, enc_wr, flag, caut_out, motion, power, l1, l2, l3;
	logic [1:0]  panel;
	int          fail_count = 0, check_count = 0;
	assign code = {l3, l2, l1};
	always #2 mclk = ~mclk;
	sfs_top #(.HOLD_CYC(HOLD)) i_sfs_top (.MCLK(mclk), .RSTN(rstn), .REG_ADDR(addr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ(irq),
		.KEY_MODE(keys[3]), .KEY_UP(keys[2]), .KEY_DOWN(keys[1]), .KEY_SHIFT(keys[0]),
		.EXT_FAULT_RESET_KEY(ext_key), .FAULT_CLEAR_INPUT(clr), .FAULT_REQ(freq),
		.FAULT_REQ_CODE(freq_code), .FAULT_REQ_ENC(fenc), .CAUTION_ACTIVE(caut),
		.CAUTION_CODE(caut_code), .ENC_LIMIT_STORED(enc_lim), .ENC_WRITE(enc_wr),
		.ENC_WRITE_DATA(enc_wdata), .MOTOR_SPEED(speed), .FAULT_FLAG_OUTPUT(flag),
		.FAULT_CODE_LINE_1(l1), .FAULT_CODE_LINE_2(l2), .FAULT_CODE_LINE_3(l3),
		.CAUTION_OUTPUT(caut_out), .MOTION_DETECT_OUTPUT(motion), .PANEL_STATE(panel));
	sfs_host_model i_sfs_host_model (.mclk(mclk), .clr_req(clr_req), .flag(flag),
		.enc_wr(enc_wr), .enc_wr_data(enc_wdata), .enc_limit_ff(enc_lim), .clear_out(clr),
		.main_power(power));
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// release with the control write already on the bus, so the boot edge takes it
	task automatic do_reset(input logic [2:0] c);
		@(posedge mclk);
		rstn <= 1'b0;
		repeat (16) @(posedge mclk);
		{rstn, addr, wdata, wr} <= {1'b1, `SFS_OFS_CTRL, 29'h0, c, 1'b1};
		@(posedge mclk);
		wr <= 1'b0;
		repeat (2) @(posedge mclk);
	endtask
	task automatic wr32(input logic [7:0] a, input logic [31:0] v);
		@(posedge mclk);
		{addr, wdata, wr} <= {a, v, 1'b1};
		@(posedge mclk);
		wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd32(input logic [7:0] a);
		@(posedge mclk);
		{addr, rd} <= {a, 1'b1};
		@(posedge mclk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	// bounded wait on the fault flag; running out ends the run
	task automatic wait_flag(input logic v);
		for (int n = 0; n < 40 && flag !== v; n++) begin
			@(posedge mclk);
			#1;
		end
		if (flag !== v) begin
			fail_count++;
			give_verdict();
		end
	endtask
	task automatic press(input logic [3:0] k, input int n);
		@(posedge mclk);
		keys <= k;
		repeat (n) @(posedge mclk);
		keys <= 4'h0;
		repeat (2) @(posedge mclk);
		#1;
	endtask
	task automatic t_motion;
		rd32(`SFS_OFS_MOTION_LVL);
		chk("level reset", 32'h14, d);
		rd32(8'hFC);
		chk("unmapped", 32'h0, d);
		wr32(`SFS_OFS_MOTION_LVL, 32'h0);
		rd32(`SFS_OFS_MOTION_LVL);
		chk("level low clamp", 32'h1, d);
		wr32(`SFS_OFS_MOTION_LVL, 32'hFFFF);
		rd32(`SFS_OFS_MOTION_LVL);
		chk("level high clamp", 32'h2710, d);
		wr32(`SFS_OFS_CTRL, 32'h6);
		wr32(`SFS_OFS_MOTION_LVL, 32'h64);
		speed <= 16'h0063;
		repeat (3) @(posedge mclk);
		#1 chk("below level", 32'h0, motion);
		@(posedge mclk);
		speed <= 16'h0064;
		repeat (3) @(posedge mclk);
		#1 chk("at level", 32'h1, motion);
	endtask
	task automatic t_clear;
		wr32(`SFS_OFS_INT_MASK, 32'h1);
		for (int m = 0; m < 3; m++) begin
			@(posedge mclk);
			{freq, freq_code} <= {1'b1, 3'h5};
			@(posedge mclk);
			freq <= 1'b0;
			wait_flag(1'b0);
			chk("fault code", 32'h5, code);
			chk("irq raised", 32'h1, irq);
			chk("main power", 32'h0, power);
			@(posedge mclk);
			if (m == 0) clr_req <= 1'b1;
			else if (m == 1) keys <= 4'h6;
			else ext_key <= 1'b1;
			repeat (2) @(posedge mclk);
			{clr_req, ext_key, keys} <= 6'h00;
			wait_flag(1'b1);
			chk("flag closed", 32'h1, flag);
			chk("idle code", 32'h7, code);
			wr32(`SFS_OFS_INT_STATUS, 32'hF);
			rd32(`SFS_OFS_INT_STATUS);
			chk("status cleared", 32'h0, d);
			chk("irq low", 32'h0, irq);
		end
		// encoder related fault ignores the clear input, only a restart removes it
		@(posedge mclk);
		{freq, fenc} <= 2'h3;
		@(posedge mclk);
		{freq, fenc} <= 2'h0;
		wait_flag(1'b0);
		@(posedge mclk);
		clr_req <= 1'b1;
		repeat (4) @(posedge mclk);
		clr_req <= 1'b0;
		#1 chk("enc fault held", 32'h0, flag);
		do_reset(3'h6);
		chk("enc fault restart", 32'h1, flag);
	endtask
	task automatic t_caution;
		@(posedge mclk);
		{caut, caut_code} <= {1'b1, 3'h3};
		repeat (3) @(posedge mclk);
		#1 chk("caution on", 32'h1, caut_out);
		chk("fault codes only", 32'h7, code);
		@(posedge mclk);
		caut <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 chk("caution off", 32'h0, caut_out);
		// restart with caution codes selected and no caution or motion pin assigned
		do_reset(3'h1);
		caut <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk("caution unassigned", 32'h0, caut_out);
		chk("caution code", 32'h3, code);
		chk("motion unassigned", 32'h0, motion);
		@(posedge mclk);
		freq <= 1'b1;
		@(posedge mclk);
		freq <= 1'b0;
		wait_flag(1'b0);
		chk("fault over caution", 32'h5, code);
		@(posedge mclk);
		clr_req <= 1'b1;
		@(posedge mclk);
		clr_req <= 1'b0;
		wait_flag(1'b1);
		chk("caution code back", 32'h3, code);
		@(posedge mclk);
		caut <= 1'b0;
		repeat (3) @(posedge mclk);
		#1 chk("caution code gone", 32'h7, code);
	endtask
	task automatic t_mismatch;
		wr32(`SFS_OFS_WRAP_LIMIT, 32'h63);
		wait_flag(1'b0);
		chk("mismatch code", 32'h2, code);
		@(posedge mclk);
		clr_req <= 1'b1;
		repeat (6) @(posedge mclk);
		clr_req <= 1'b0;
		#1 chk("not cleared", 32'h0, flag);
		press(4'h8, 1);
		for (int i = 0; i < 19; i++) press(4'h4, 1);
		press(4'h1, HOLD + 3);
		chk("prompt", 32'h2, panel);
		press(4'h8, 1);
		chk("encoder data", 32'h63, enc_lim);
		chk("done flash", 32'h3, panel);
		repeat (HOLD) @(posedge mclk);
		#1 chk("back to prompt", 32'h2, panel);
		press(4'h1, HOLD + 3);
		chk("utility", 32'h1, panel);
		rd32(`SFS_OFS_ENC_LIMIT);
		chk("limit before restart", 32'hFFFF, d);
		do_reset(3'h0);
		rd32(`SFS_OFS_ENC_LIMIT);
		chk("limit after restart", 32'h63, d);
	endtask
	initial begin
		do_reset(3'h0);
		t_motion();
		t_clear();
		t_caution();
		t_mismatch();
		give_verdict();
	end
endmodule // tb
